// ==== design/fspg_pkg.sv ====
// Shared constants and carriers for the flash self-program guard.
// Assumes a word-addressed program flash and a core that issues one request per cycle.
package fspg_pkg;
   localparam int FSPG_AW            = 12;           // Flash word address width
   localparam int FSPG_DW            = 8;            // Register data width
   // Register map of the plain register port
   localparam logic [3:0] FSPG_OFF_CTRL   = 4'h0;    // Program-store control
   localparam logic [3:0] FSPG_OFF_PROT   = 4'h1;    // Protection bits
   localparam logic [3:0] FSPG_OFF_STAT   = 4'h2;    // Status
   // Control register fields
   localparam int FSPG_CTRL_EN       = 0;            // Store enable
   localparam int FSPG_CTRL_ERASE    = 1;            // Page erase
   localparam int FSPG_CTRL_WRITE    = 2;            // Page write
   localparam int FSPG_CTRL_LOCK     = 3;            // Set protection bits
   localparam int FSPG_CTRL_REEN     = 4;            // Clear busy flag
   localparam int FSPG_CTRL_BUSY     = 6;            // Concurrent-read busy flag
   // Protection register fields (one = unprogrammed)
   localparam int FSPG_PROT_APP_LO   = 0;
   localparam int FSPG_PROT_APP_HI   = 1;
   localparam int FSPG_PROT_BOOT_LO  = 2;
   localparam int FSPG_PROT_BOOT_HI  = 3;
   localparam logic [3:0] FSPG_PROT_RESET = 4'hF;    // Erased state
   // Timing: store must follow control write within four cycles
   localparam int FSPG_ARM_CYCLES    = 4;
   localparam int FSPG_PROG_TIME_US  = 4;            // Nominal page operation time
   localparam int FSPG_CLK_MHZ       = 20;
   localparam int FSPG_PROG_CYCLES   = FSPG_PROG_TIME_US * FSPG_CLK_MHZ;
   // Boot size fuse decode: boot region words for each code
   localparam logic [FSPG_AW-1:0] FSPG_BOOT_W0 = 12'h400;
   localparam logic [FSPG_AW-1:0] FSPG_BOOT_W1 = 12'h200;
   localparam logic [FSPG_AW-1:0] FSPG_BOOT_W2 = 12'h100;
   localparam logic [FSPG_AW-1:0] FSPG_BOOT_W3 = 12'h080;
   localparam logic [FSPG_AW-1:0] FSPG_HALT_START = 12'hC00; // Halting region start

   typedef struct packed {
      logic                store;   // Store-to-program strobe
      logic                load;    // Load-from-program strobe
      logic [FSPG_AW-1:0]  pc;      // Address of the issuing instruction
      logic [FSPG_AW-1:0]  target;  // Flash word targeted
   } fspg_req_type;

   typedef enum logic [1:0] {FSPG_OP_NONE, FSPG_OP_ERASE, FSPG_OP_WRITE, FSPG_OP_LOCK} fspg_op_type;
endpackage : fspg_pkg

// ==== design/fspg_guard.sv ====
// Access guard and section logic for flash self-programming.
// Assumes fuse inputs are static; core holds one request per cycle and obeys the stall.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// - No programming from application region code
// - Boot code may program any unprotected page
// - Region boundary set by boot size fuses
// - Concurrent-region programming keeps CPU running
// - Halting-region programming stalls CPU, blocks reads
// - Busy flag reads one while region blocked
// - Region stays blocked until software clears flag
// - Boot region always inside halting region
// - Protection bits set by software, cleared by erase
// - General lock modes ignore self-programming
// - App bits unprogrammed mean no restriction
// - App modes two, three refuse stores
// - App modes three, four block boot loads
// - App modes three, four mask application interrupts
// - Boot bits unprogrammed mean no restriction
// - Boot modes two, three refuse stores
// - Boot modes three, four block application loads
// - Boot modes three, four mask boot interrupts
module fspg_guard
   import fspg_pkg::*;
#(
   parameter int                 PROG_CYCLES = FSPG_PROG_CYCLES,
   parameter logic [FSPG_DW-1:0] READ_FILL   = 8'hFF
) (
   input  wire logic               i_sys_clk,
   input  wire logic               i_rst_n,
   input  wire logic [1:0]         i_boot_size_fuses,
   input  wire logic               i_chip_erase,
   input  wire logic [1:0]         i_lock_mode,
   input  wire logic               i_ext_prot_wr,
   input  wire logic [3:0]         i_ext_prot_data,
   input  wire logic               i_vectors_in_boot,
   input  wire fspg_req_type       i_req,
   input  wire logic [FSPG_DW-1:0] i_flash_rdata,
   input  wire logic [3:0]         i_reg_addr,
   input  wire logic [FSPG_DW-1:0] i_reg_wdata,
   input  wire logic               i_reg_wr,
   input  wire logic               i_reg_rd,
   output logic [FSPG_DW-1:0]      o_reg_rdata,
   output logic                    o_cpu_stall,
   output logic                    o_load_ok,
   output logic [FSPG_DW-1:0]      o_load_data,
   output logic                    o_prog_start,
   output fspg_op_type             o_prog_op,
   output logic [FSPG_AW-1:0]      o_prog_addr,
   output logic                    o_store_refused,
   output logic                    o_irq_mask,
   output logic                    o_conc_blocked
);
   localparam int CW = $clog2(PROG_CYCLES + 1);

   typedef enum logic [1:0] {FSPG_IDLE, FSPG_PROG_CONC, FSPG_PROG_HALT} fspg_state_type;

   // Reset release through two flip-flops
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Boot region size from fuses, placed at top of flash
   function automatic logic [FSPG_AW-1:0] boot_start(input logic [1:0] fz);
      logic [FSPG_AW-1:0] w;
      w = FSPG_BOOT_W0;
      unique case (fz)
         2'h0: w = FSPG_BOOT_W0;
         2'h1: w = FSPG_BOOT_W1;
         2'h2: w = FSPG_BOOT_W2;
         2'h3: w = FSPG_BOOT_W3;
      endcase
      return FSPG_AW'(0) - w;
   endfunction : boot_start

   logic [7:0]          ctrl;
   logic [3:0]          prot;
   logic [2:0]          arm_cnt;
   logic                busy;
   logic [CW-1:0]       prog_cnt;
   fspg_state_type      state;
   fspg_state_type      next_state;

   // Region decode
   wire logic [FSPG_AW-1:0] bstart      = boot_start(i_boot_size_fuses);
   wire logic               pc_in_boot  = (i_req.pc >= bstart);
   wire logic               tg_in_boot  = (i_req.target >= bstart);
   wire logic               tg_in_halt  = (i_req.target >= FSPG_HALT_START);

   // Protection modes; lock mode input deliberately unused
   wire logic app_no_store  = ~prot[FSPG_PROT_APP_LO];
   wire logic app_no_load   = ~prot[FSPG_PROT_APP_HI];
   wire logic boot_no_store = ~prot[FSPG_PROT_BOOT_LO];
   wire logic boot_no_load  = ~prot[FSPG_PROT_BOOT_HI];
   wire logic unused_lock   = ^i_lock_mode;

   // Store decision
   wire logic armed       = (arm_cnt != 3'h0);
   wire logic is_lock     = ctrl[FSPG_CTRL_LOCK];
   wire logic tg_locked   = tg_in_boot ? boot_no_store : app_no_store;
   wire logic store_valid = i_req.store & armed & pc_in_boot & (state == FSPG_IDLE);
   wire logic store_go    = store_valid & (is_lock | ~tg_locked);
   wire logic is_page_op  = ctrl[FSPG_CTRL_ERASE] | ctrl[FSPG_CTRL_WRITE];

   // Load decision
   wire logic ld_blocked  = pc_in_boot ? (~tg_in_boot & app_no_load)
                                       : (tg_in_boot & boot_no_load);
   wire logic ld_conc     = ~tg_in_halt & busy;
   wire logic load_ok     = i_req.load & ~ld_blocked & ~ld_conc & (state != FSPG_PROG_HALT);

   // Next state of the programming sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         FSPG_IDLE:      if (store_go & ~is_lock & is_page_op)
                            next_state = tg_in_halt ? FSPG_PROG_HALT : FSPG_PROG_CONC;
         FSPG_PROG_CONC,
         FSPG_PROG_HALT: if (prog_cnt == CW'(1)) next_state = FSPG_IDLE;
      endcase
   end

   // Sequencer and operation counter
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= FSPG_IDLE;
         prog_cnt <= '0;
      end else begin
         state    <= next_state;
         prog_cnt <= (state == FSPG_IDLE) ? CW'(PROG_CYCLES) : prog_cnt - CW'(1);
      end
   end

   // Control register and arm window
   wire logic ctrl_wr = i_reg_wr & (i_reg_addr == FSPG_OFF_CTRL);
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl    <= '0;
         arm_cnt <= '0;
      end else if (ctrl_wr) begin
         ctrl    <= i_reg_wdata;
         arm_cnt <= 3'(FSPG_ARM_CYCLES);
      end else if (i_req.store | armed) begin
         arm_cnt <= i_req.store ? 3'h0 : arm_cnt - 3'h1;
         if (i_req.store | arm_cnt == 3'h1) ctrl <= '0;
      end
   end

   // Busy flag: set on concurrent programming, held until software clears
   wire logic busy_set = (next_state == FSPG_PROG_CONC) & (state == FSPG_IDLE);
   wire logic busy_clr = ctrl_wr & i_reg_wdata[FSPG_CTRL_REEN] & ~i_reg_wdata[FSPG_CTRL_EN]
                         & (state != FSPG_PROG_CONC);
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n)        busy <= 1'b0;
      else if (busy_set) busy <= 1'b1;
      else if (busy_clr) busy <= 1'b0;
   end

   // Protection bits: software and external may only program to zero
   wire logic sw_lock = store_go & is_lock;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n)            prot <= FSPG_PROT_RESET;
      else if (i_chip_erase) prot <= FSPG_PROT_RESET;
      else if (sw_lock | i_ext_prot_wr)
         prot <= prot & (sw_lock ? i_reg_wdata[3:0] : 4'hF)
                      & (i_ext_prot_wr ? i_ext_prot_data : 4'hF);
   end

   // Programming request outputs and load data
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_prog_start    <= 1'b0;
         o_prog_op       <= FSPG_OP_NONE;
         o_prog_addr     <= '0;
         o_store_refused <= 1'b0;
         o_load_ok       <= 1'b0;
         o_load_data     <= '0;
         o_reg_rdata     <= '0;
      end else begin
         o_prog_start    <= store_go & ~is_lock & is_page_op;
         o_store_refused <= i_req.store & ~store_go;
         if (store_go)
            o_prog_op <= is_lock ? FSPG_OP_LOCK :
                         ctrl[FSPG_CTRL_ERASE] ? FSPG_OP_ERASE : FSPG_OP_WRITE;
         if (store_go) o_prog_addr <= i_req.target;
         o_load_ok   <= load_ok;
         o_load_data <= load_ok ? i_flash_rdata : READ_FILL;
         o_reg_rdata <= '0;
         if (i_reg_rd) begin
            unique case (i_reg_addr)
               FSPG_OFF_CTRL: o_reg_rdata <= {1'b0, busy, ctrl[5:0]};
               FSPG_OFF_PROT: o_reg_rdata <= {4'h0, prot};
               FSPG_OFF_STAT: o_reg_rdata <= {5'h0, unused_lock & 1'b0, state};
               default:       o_reg_rdata <= '0;
            endcase
         end
      end
   end

   // Core-facing status
   assign o_cpu_stall    = (state == FSPG_PROG_HALT);
   assign o_conc_blocked = busy;
   // Interrupts masked while running away from the vector region, if the running section's load-lock bit is programmed
   assign o_irq_mask     = pc_in_boot ? (~i_vectors_in_boot & boot_no_load)
                                      : ( i_vectors_in_boot & app_no_load);

   // Checks
   chk_app_store_block: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (i_req.store & ~pc_in_boot) |=> !o_prog_start) else $error("store from application started");
   chk_halt_stall: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (state == FSPG_IDLE && next_state == FSPG_PROG_HALT) |=> o_cpu_stall [*2])
      else $error("halting program did not stall");
   chk_conc_no_stall: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (state == FSPG_PROG_CONC) |-> !o_cpu_stall && busy) else $error("concurrent program stalled");
   chk_busy_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (busy && !busy_clr) |=> busy) else $error("busy flag dropped");
   chk_app_prot_store: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (i_req.store && !is_lock && !tg_in_boot && app_no_store) |=> !o_prog_start)
      else $error("protected application store");
   chk_boot_prot_store: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (i_req.store && !is_lock && tg_in_boot && boot_no_store) |=> !o_prog_start)
      else $error("protected boot store");
   chk_boot_in_halt: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      bstart >= FSPG_HALT_START) else $error("boot region outside halting region");
   chk_prot_sticky: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (!i_chip_erase) |=> ((prot & ~$past(prot)) == 4'h0)) else $error("protection bit erased");
   // A fresh control write restarts the window, so it ends the watch
   chk_arm_window: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      ctrl_wr ##1 (!i_req.store && !ctrl_wr) [*4] |=> !armed) else $error("arm window too long");
   chk_load_block: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (i_req.load && pc_in_boot && !tg_in_boot && app_no_load) |=> !o_load_ok)
      else $error("blocked load passed");
   chk_boot_load_block: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (i_req.load && !pc_in_boot && tg_in_boot && boot_no_load) |=> o_load_data == READ_FILL)
      else $error("blocked boot load passed");

   // Busy flag readback and reads around programming
   chk_busy_reads_one: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (i_reg_rd && i_reg_addr == FSPG_OFF_CTRL) |=> (o_reg_rdata[FSPG_CTRL_BUSY] == $past(busy)))
      else $error("busy flag misread");
   chk_halt_load_ok: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (i_req.load && tg_in_halt && !ld_blocked && state == FSPG_PROG_CONC) |=> o_load_ok)
      else $error("halting region read refused");
   chk_halt_no_load: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (state == FSPG_PROG_HALT) |=> !o_load_ok) else $error("read during halting program");

   // Unprogrammed protection bits leave stores alone
   chk_app_free_store: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (store_valid && !tg_in_boot && prot[FSPG_PROT_APP_LO] && prot[FSPG_PROT_APP_HI]) |-> store_go)
      else $error("free application store refused");
   chk_boot_free_store: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (store_valid && tg_in_boot && prot[FSPG_PROT_BOOT_LO] && prot[FSPG_PROT_BOOT_HI]) |-> store_go)
      else $error("free boot store refused");

   // Interrupt masking and refused stores
   chk_app_irq_mask: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (!pc_in_boot && i_vectors_in_boot && app_no_load) |-> o_irq_mask)
      else $error("application interrupt not masked");
   chk_boot_irq_mask: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      (pc_in_boot && !i_vectors_in_boot && boot_no_load) |-> o_irq_mask)
      else $error("boot interrupt not masked");
   chk_refuse_no_start: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
      o_store_refused |-> !o_prog_start) else $error("refused store started");
endmodule : fspg_guard

// ==== verif/fspg_core_model.sv ====
// Behavioural core that issues store and load requests to the guard.
// Assumes the bench asks for one request at a time and keeps off the busy region.
`timescale 1ns/1ps
module fspg_core_model
   import fspg_pkg::*;
(
   input  wire logic          i_sys_clk,
   input  wire logic          i_stall,
   input  wire logic          i_go,
   input  wire fspg_req_type  i_cmd,
   output fspg_req_type       o_req = '0,
   output logic [FSPG_DW-1:0] o_flash_rdata
);
   logic [FSPG_DW-1:0] noise = 8'h00;
   // One-cycle request, never issued while the core is halted
   always @(posedge i_sys_clk) begin
      o_req <= (i_go && !i_stall) ? i_cmd : '0;
      noise <= noise + 8'h3B;
   end
   // Flash answers during a load only, otherwise churns
   assign o_flash_rdata = o_req.load ? (o_req.target[7:0] ^ 8'hA5) : noise;
endmodule : fspg_core_model

// ==== verif/fspg_guard_tb.sv ====
// Self-checking bench for the flash self-program guard against a reference model.
// Assumes registered outputs follow each request by one cycle and a short page time.
`timescale 1ns/1ps
module fspg_guard_tb
   import fspg_pkg::*;
;
   localparam int PROG = 4;
   logic         i_sys_clk = 1'b0, i_rst_n = 1'b0, i_chip_erase = 1'b0, i_ext_prot_wr = 1'b0;
   logic         i_vectors_in_boot = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, go = 1'b0;
   logic [1:0]   i_boot_size_fuses = 2'h0, i_lock_mode = 2'h0;
   logic [3:0]   i_ext_prot_data = 4'hF, i_reg_addr = 4'h0, prot = 4'hF;
   logic [7:0]   i_reg_wdata = 8'h00, d, flash, o_reg_rdata, o_load_data;
   logic [11:0]  pc, tg, o_prog_addr;
   logic [31:0]  r;
   logic         o_cpu_stall, o_load_ok, o_prog_start, o_store_refused, o_irq_mask, o_conc_blocked;
   fspg_op_type  o_prog_op;
   fspg_req_type req, cmd = '0;
   int           n_errors = 0, n_tests = 0, cyc = 0, seed = 32'h3B62;

   fspg_guard #(.PROG_CYCLES(PROG)) dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_boot_size_fuses(i_boot_size_fuses), .i_chip_erase(i_chip_erase), .i_lock_mode(i_lock_mode),
      .i_ext_prot_wr(i_ext_prot_wr), .i_ext_prot_data(i_ext_prot_data), .i_vectors_in_boot(i_vectors_in_boot),
      .i_req(req), .i_flash_rdata(flash), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_cpu_stall(o_cpu_stall),
      .o_load_ok(o_load_ok), .o_load_data(o_load_data), .o_prog_start(o_prog_start), .o_prog_op(o_prog_op),
      .o_prog_addr(o_prog_addr), .o_store_refused(o_store_refused), .o_irq_mask(o_irq_mask),
      .o_conc_blocked(o_conc_blocked));
   fspg_core_model core_u (.i_sys_clk(i_sys_clk), .i_stall(o_cpu_stall), .i_go(go), .i_cmd(cmd),
      .o_req(req), .o_flash_rdata(flash));

   // Clock and hang guard
   initial forever #25 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Register port cycles
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= v;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_sys_clk);
      d = o_reg_rdata;
   endtask : rd

   // Chip erase, then external programming of protection bits
   task automatic prot_set(input logic [3:0] p);
      @(posedge i_sys_clk);
      i_chip_erase <= 1'b1;
      @(posedge i_sys_clk);
      i_chip_erase <= 1'b0;
      i_ext_prot_wr <= 1'b1;
      i_ext_prot_data <= p;
      @(posedge i_sys_clk);
      i_ext_prot_data <= 4'hF;
      @(posedge i_sys_clk);
      i_ext_prot_wr <= 1'b0;
      prot = p;
      rd(FSPG_OFF_PROT);
      check(d[3:0], p);
   endtask : prot_set

   function automatic logic [11:0] bstart(input logic [1:0] f);
      return 12'h000 - (12'h400 >> f);
   endfunction : bstart

   // Control write, store or load after a lag, then compare with the reference
   task automatic op(input logic st, input logic ld, input logic [7:0] ctl, input logic [3:0] m, input int lag);
      logic pb, tb_, ok, blk;
      pb = pc >= bstart(i_boot_size_fuses);
      tb_ = tg >= bstart(i_boot_size_fuses);
      ok = st && lag <= 3 && pb && (ctl[3] || (tb_ ? prot[2] : prot[0]));
      blk = (pb && !tb_ && !prot[1]) || (!pb && tb_ && !prot[3]);
      @(posedge i_sys_clk);
      if (st) begin
         i_reg_wr <= 1'b1;
         i_reg_addr <= FSPG_OFF_CTRL;
         i_reg_wdata <= ctl;
      end
      repeat (lag) @(posedge i_sys_clk) i_reg_wr <= 1'b0;
      go <= 1'b1;
      cmd <= '{store: st, load: ld, pc: pc, target: tg};
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
      go <= 1'b0;
      i_reg_wdata <= {4'h0, m};
      @(negedge i_sys_clk);
      check(o_irq_mask, i_vectors_in_boot ? (!pb && !prot[1]) : (pb && !prot[3]));
      @(negedge i_sys_clk);
      if (st) check(o_store_refused, !ok);
      if (st && !ctl[3]) check(o_prog_start, ok);
      if (ld) check({o_load_ok, o_load_data}, {!blk, blk ? 8'hFF : tg[7:0] ^ 8'hA5});
      if (ok && ctl[3]) prot = prot & m;
      if (ok && !ctl[3]) begin
         check({o_prog_op, o_prog_addr}, {ctl[2] ? FSPG_OP_WRITE : FSPG_OP_ERASE, tg});
         check(o_cpu_stall, tg >= 12'hC00);
         // Halting-region read while the concurrent region is busy
         if (tg < 12'hC00) begin
            @(posedge i_sys_clk);
            go <= 1'b1;
            cmd <= '{store: 1'b0, load: 1'b1, pc: 12'hFFF, target: 12'hFFE};
            @(posedge i_sys_clk);
            go <= 1'b0;
            repeat (2) @(negedge i_sys_clk);
            check({o_load_ok, o_load_data}, {1'b1, 8'hFE ^ 8'hA5});
         end
         repeat (PROG + 2) @(negedge i_sys_clk);
         check({o_cpu_stall, o_conc_blocked}, {1'b0, tg < 12'hC00});
         rd(FSPG_OFF_CTRL);
         check(d[6], tg < 12'hC00);
         wr(FSPG_OFF_CTRL, 8'h10);
         rd(FSPG_OFF_CTRL);
         check(d[6], 1'b0);
      end
   endtask : op

   // Main sequence
   initial begin
      repeat (3) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      rd(FSPG_OFF_PROT);
      check(d[3:0], FSPG_PROT_RESET);
      rd(4'hF);
      check(d, 8'h00);
      pc = 12'hFFF;
      tg = 12'h010;
      op(1'b1, 1'b0, 8'h05, 4'h0, 6);
      op(1'b1, 1'b0, 8'h05, 4'h0, 2);
      op(1'b1, 1'b0, 8'h05, 4'h0, 3);
      op(1'b1, 1'b0, 8'h05, 4'h0, 4);
      op(1'b1, 1'b0, 8'h09, 4'h3, 0);
      rd(FSPG_OFF_PROT);
      check(d[3:0], prot);
      for (int f = 0; f < 4; f++) begin
         for (int p = 0; p < 16; p++) begin
            i_boot_size_fuses <= f[1:0];
            prot_set(p[3:0]);
            repeat (4) begin
               r = $random(seed);
               i_lock_mode <= r[7:6];
               i_vectors_in_boot <= r[8];
               pc = r[0] ? bstart(f[1:0]) : bstart(f[1:0]) - 12'h001;
               tg = r[1] ? bstart(f[1:0]) : (r[2] ? bstart(f[1:0]) - 12'h001 : r[20:9]);
               op(r[4], !r[4], r[5] ? 8'h05 : 8'h03, 4'hF, 0);
            end
         end
      end
      give_verdict();
   end
endmodule : fspg_guard_tb
